// [shared/asf_consts.svh]
// Register offsets, field positions and reset values of the acquisition status flags.
`ifndef ASF_CONSTS_SVH
`define ASF_CONSTS_SVH
`define ASF_OFS_ACQ_STATUS   4'h0
`define ASF_OFS_ERR_DETAIL   4'h1
`define ASF_OFS_CONTROL      4'h8
`define ASF_OFS_ACQ_CLEAR    4'h9
`define ASF_OFS_CNT_CLEAR    4'hA
`define ASF_BIT_WAITING      0
`define ASF_BIT_ERROR        1
`define ASF_BIT_COUNTER      2
`define ASF_BIT_EXT_LINE     3
`define ASF_BIT_OVERRUN      0
`define ASF_BIT_OVERFLOW     1
`define ASF_BIT_EXT_EN       0
`define ASF_BIT_CNT_EN       1
`define ASF_CONTROL_RESET    2'h0
`endif

// [shared/asf_pkg.sv]
// Types shared by the acquisition status flags block.
package asf_pkg;
    typedef enum logic [1:0] {
        ASF_ORIGINAL = 2'b00,
        ASF_ENHANCED = 2'b01
    } asf_variant_t;
endpackage : asf_pkg

// [core/asf_status_flags.sv]
// Acquisition status and error flag register bank on a classic Wishbone slave.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "asf_consts.svh"
// How it works
// - Status bit 3 shows the external interrupt line level live.
// - Enable set and bit 3 low means the external line caused the interrupt.
// - With counter enable set, counter 2 rising edge sets bit 2, requests interrupt.
// - Counter flag stays set until any write to the counter clear port.
// - Original board: bit 1 means buffer overflow or conversion overrun.
// - Enhanced board: bit 1 means buffer overflow only.
// - Any write to the acquisition clear port clears the combined error flag.
// - Bit 0 is set while a result waits and clears when buffer empties.
// - Original board: acquisition clear sets bit 0 until one word is read.
// - Enhanced board: bit 0 exactly tracks buffer occupancy.
// - Enhanced board only has the read-only error detail register at 01 hex.
// - Error detail bit 1 records a buffer overflow.
// - Error detail bit 0 records a conversion overrun, cleared by acquisition clear.
// - Acquisition clear resets the acquisition circuitry, buffer and error flags.
module asf_status_flags #(
    parameter asf_pkg::asf_variant_t VARIANT = asf_pkg::ASF_ENHANCED
) (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [7:0]  wb_dat_i,
    output logic      [7:0]  wb_dat_o,
    output logic             wb_ack_o,
    // Acquisition side.
    input  wire logic        external_irq_line_n,
    input  wire logic        counter2_out,
    input  wire logic        buffer_not_empty,
    input  wire logic        buffer_overflow,
    input  wire logic        conversion_overrun,
    input  wire logic        buffer_word_read,
    output logic             acquisition_reset,
    output logic             counter_irq,
    output logic             external_irq_source
);

    // ========================================================================
    // Elaboration check
    generate
        if (VARIANT != asf_pkg::ASF_ORIGINAL && VARIANT != asf_pkg::ASF_ENHANCED) begin : g_bad
            $error("asf_status_flags: VARIANT must be original or enhanced");
        end
    endgenerate

    localparam logic IS_ENH = (VARIANT == asf_pkg::ASF_ENHANCED);

    // ========================================================================
    // Bus decode
    logic [1:0] control;
    logic       counter_event_flag;
    logic       overflow_flag;
    logic       overrun_flag;
    logic       clear_set_waiting;
    logic       counter_prev;
    logic [7:0] next_dat;

    wire bus_req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr      = bus_req && wb_we_i;
    wire hit_ctrl    = (wb_adr_i == `ASF_OFS_CONTROL);
    wire acquisition_clear_port   = bus_wr && (wb_adr_i == `ASF_OFS_ACQ_CLEAR);
    wire counter_event_clear_port = bus_wr && (wb_adr_i == `ASF_OFS_CNT_CLEAR);
    wire external_irq_enable      = control[`ASF_BIT_EXT_EN];
    wire counter_event_enable     = control[`ASF_BIT_CNT_EN];
    wire counter_rise = counter2_out && !counter_prev;

    // Original board folds overrun into the combined flag; enhanced does not.
    wire combined_error_flag = IS_ENH ? overflow_flag
                                      : (overflow_flag || overrun_flag);
    // The clear-port quirk makes the original board look busy until one word drains.
    wire result_waiting_flag = IS_ENH ? buffer_not_empty
                                      : (buffer_not_empty || clear_set_waiting);

    wire [7:0] acq_status = {4'h0, ~external_irq_line_n ? 1'b0 : 1'b1,
                             counter_event_flag, combined_error_flag, result_waiting_flag};
    wire [7:0] err_detail = {6'h00, overflow_flag, overrun_flag};

    always_comb begin
        next_dat = 8'h00;
        if (wb_adr_i == `ASF_OFS_ACQ_STATUS) begin
            next_dat = acq_status;
        end else if (IS_ENH && wb_adr_i == `ASF_OFS_ERR_DETAIL) begin
            next_dat = err_detail;
        end else if (hit_ctrl) begin
            next_dat = {6'h00, control};
        end
    end

    assign acquisition_reset   = acquisition_clear_port;
    assign counter_irq         = counter_event_flag;
    assign external_irq_source = external_irq_enable && !external_irq_line_n;

    // ========================================================================
    // Bus answer: one wait-free cycle, reads have no side effects.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 8'h00;
            control  <= `ASF_CONTROL_RESET;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= next_dat;
            end
            if (bus_wr && hit_ctrl) begin
                control <= wb_dat_i[1:0];
            end
        end
    end

    // ========================================================================
    // Flags: a hardware event in the same cycle as a clear wins; only the pseudo waiting bit lets the clear win over a word read.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_prev       <= 1'b0;
            counter_event_flag <= 1'b0;
            overflow_flag      <= 1'b0;
            overrun_flag       <= 1'b0;
            clear_set_waiting  <= 1'b0;
        end else begin
            counter_prev <= counter2_out;
            if (counter_event_enable && counter_rise) begin
                counter_event_flag <= 1'b1;
            end else if (counter_event_clear_port) begin
                counter_event_flag <= 1'b0;
            end
            if (buffer_overflow) begin
                overflow_flag <= 1'b1;
            end else if (acquisition_clear_port) begin
                overflow_flag <= 1'b0;
            end
            if (conversion_overrun) begin
                overrun_flag <= 1'b1;
            end else if (acquisition_clear_port) begin
                overrun_flag <= 1'b0;
            end
            if (!IS_ENH && acquisition_clear_port) begin
                clear_set_waiting <= 1'b1;
            end else if (buffer_word_read) begin
                clear_set_waiting <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Checks: external line and its attribution.
    // The pin is passed through without a register, so these hold every cycle.
    // A stuck or inverted pin path shows at the first edge after reset.
    ext_line_live_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        acq_status[`ASF_BIT_EXT_LINE] == external_irq_line_n)
        else $error("external line bit does not follow pin");

    ext_source_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        external_irq_source == (external_irq_enable && !acq_status[3]))
        else $error("external source attribution wrong");

    ext_no_enable_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !external_irq_enable |-> !external_irq_source)
        else $error("external source without enable");

    src_low_line_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        external_irq_line_n |-> !external_irq_source)
        else $error("external source with idle line");

    // ========================================================================
    // Checks: counter event flag.
    // Set wins over clear, so a clear that meets an edge leaves the flag set.
    cnt_set_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        counter_event_enable && counter_rise |=> counter_event_flag)
        else $error("counter edge did not set flag");

    cnt_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        counter_event_flag && !counter_event_clear_port |=> counter_event_flag)
        else $error("counter flag dropped without clear");

    cnt_no_enable_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !counter_event_flag && !(counter_event_enable && counter_rise) |=> !counter_event_flag)
        else $error("counter flag set without enabled edge");

    cnt_clear_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        counter_event_clear_port && !counter_rise |=> !counter_event_flag)
        else $error("counter clear did not drop flag");

    // ========================================================================
    // Checks: error flags.
    // The combined flag is derived from the sticky detail flags on both boards.
    // Only the enhanced board keeps overruns out of the combined flag.
    err_clear_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        acquisition_clear_port && !buffer_overflow && !conversion_overrun
        |=> !combined_error_flag && err_detail[1:0] == 2'b00)
        else $error("clear did not drop error flags");

    ovf_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        overflow_flag && !acquisition_clear_port |=> overflow_flag)
        else $error("overflow flag dropped without clear");

    ovf_set_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        buffer_overflow |=> err_detail[`ASF_BIT_OVERFLOW] && combined_error_flag)
        else $error("overflow not recorded");

    ovf_quiet_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !overflow_flag && !buffer_overflow |=> !overflow_flag)
        else $error("overflow flag set without overflow");

    ovr_set_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        conversion_overrun |=> err_detail[`ASF_BIT_OVERRUN])
        else $error("overrun not recorded");

    ovr_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        overrun_flag && !acquisition_clear_port |=> overrun_flag)
        else $error("overrun flag dropped without clear");

    ovr_quiet_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !overrun_flag && !conversion_overrun |=> !overrun_flag)
        else $error("overrun flag set without overrun");

    err_enh_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        IS_ENH |-> combined_error_flag == overflow_flag)
        else $error("enhanced combined flag not overflow only");

    err_orig_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !IS_ENH |-> combined_error_flag == (overflow_flag || overrun_flag))
        else $error("original combined flag wrong");

    ovr_orig_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !IS_ENH && conversion_overrun |=> combined_error_flag)
        else $error("original overrun not in combined flag");

    detail_upper_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        err_detail[7:2] == 6'h00)
        else $error("error detail upper bits not zero");

    // ========================================================================
    // Checks: result waiting flag.
    // The original board's pseudo bit must drain on the next full word read.
    // The enhanced board must never carry it.
    waiting_track_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        IS_ENH |-> result_waiting_flag == buffer_not_empty)
        else $error("waiting flag differs from buffer");

    waiting_set_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        buffer_not_empty |-> result_waiting_flag)
        else $error("waiting flag low with data in buffer");

    clear_waiting_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !IS_ENH && acquisition_clear_port |=> result_waiting_flag)
        else $error("original clear did not set waiting flag");

    pseudo_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clear_set_waiting && !buffer_word_read |=> clear_set_waiting)
        else $error("pseudo waiting dropped without word read");

    enh_no_pseudo_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        IS_ENH |-> !clear_set_waiting)
        else $error("enhanced board holds pseudo waiting bit");

    // ========================================================================
    // Checks: bus answer and side effects.
    // A read must leave every flag alone; only events and clear writes move them.
    // The answer is always one cycle after the request is taken.
    ack_one_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    ack_answer_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        bus_req |=> wb_ack_o)
        else $error("request not answered next cycle");

    ack_idle_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !bus_req |=> !wb_ack_o)
        else $error("ack without request");

    read_data_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        bus_req && !wb_we_i |=> wb_dat_o == $past(next_dat))
        else $error("read data not the selected register");

    dat_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !(bus_req && !wb_we_i) |=> $stable(wb_dat_o))
        else $error("read data changed without read");

    orig_detail_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !IS_ENH && bus_req && !wb_we_i && wb_adr_i == `ASF_OFS_ERR_DETAIL
        |=> wb_dat_o == 8'h00)
        else $error("original board answered error detail");

    read_no_side_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        bus_req && !wb_we_i && !buffer_overflow && !conversion_overrun && !counter_rise
        |=> $stable(overflow_flag) && $stable(overrun_flag)
            && $stable(counter_event_flag) && $stable(control))
        else $error("read changed a flag");

    ctrl_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !(bus_wr && hit_ctrl) |=> $stable(control))
        else $error("control changed without write");

    clear_pulse_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        acquisition_reset |=> !acquisition_reset)
        else $error("acquisition reset longer than one cycle");

endmodule : asf_status_flags
`default_nettype wire

// [test/asf_acq_model.sv]
// Acquisition-side model: result buffer, converter and external interrupt source.
`timescale 1ns/1ps
`default_nettype none
module asf_acq_model (
    // Clock, reset and clear.
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic acquisition_reset,
    // Bench commands.
    input  wire logic push,
    input  wire logic pop,
    input  wire logic skip,
    input  wire logic irq_req,
    // Acquisition signals.
    output logic      external_irq_line_n,
    output logic      buffer_not_empty,
    output logic      buffer_overflow,
    output logic      conversion_overrun,
    output logic      buffer_word_read
);
    logic [4:0] fill;
    assign external_irq_line_n = !irq_req;
    assign buffer_not_empty = fill != 5'h00;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fill <= 5'h00;
            buffer_overflow <= 1'b0;
            conversion_overrun <= 1'b0;
            buffer_word_read <= 1'b0;
        end else begin
            buffer_overflow <= push && fill == 5'h10;
            conversion_overrun <= skip;
            buffer_word_read <= pop && fill != 5'h00;
            if (acquisition_reset) fill <= 5'h00;
            else if (push && fill != 5'h10) fill <= fill + 5'h01;
            else if (pop && fill != 5'h00) fill <= fill - 5'h01;
        end
    end
endmodule : asf_acq_model
`default_nettype wire

// [test/acquisition_status_flags_tb.sv]
// Self-checking bench for the acquisition status flags.
`timescale 1ns/1ps
`default_nettype none
module acquisition_status_flags_tb;
    logic ref_clk, rst_n, cyc, stb, we, ack, c2, push, pop, skip, irq, clr, cirq, src;
    logic ln, bne, ovf, ovr, bwr;
    logic [3:0] adr;
    logic [7:0] dat, rd, q, rd2, q2;
    int fails, compares;
    asf_status_flags uut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
        .external_irq_line_n(ln), .counter2_out(c2), .buffer_not_empty(bne),
        .buffer_overflow(ovf), .conversion_overrun(ovr), .buffer_word_read(bwr),
        .acquisition_reset(clr), .counter_irq(cirq), .external_irq_source(src));
    // Original board twin shares every input; it answers on the same cycle as uut.
    asf_status_flags #(.VARIANT(asf_pkg::ASF_ORIGINAL)) uut_orig (.ref_clk(ref_clk),
        .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_dat_o(rd2), .wb_ack_o(), .external_irq_line_n(ln),
        .counter2_out(c2), .buffer_not_empty(bne), .buffer_overflow(ovf),
        .conversion_overrun(ovr), .buffer_word_read(bwr), .acquisition_reset(),
        .counter_irq(), .external_irq_source());
    asf_acq_model far (.ref_clk(ref_clk), .rst_n(rst_n), .acquisition_reset(clr), .push(push),
        .pop(pop), .skip(skip), .irq_req(irq), .external_irq_line_n(ln),
        .buffer_not_empty(bne), .buffer_overflow(ovf), .conversion_overrun(ovr),
        .buffer_word_read(bwr));
    always #10 ref_clk = !ref_clk;
    // ==========================================
    // Shared tasks
    task automatic close_out;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    // Holds the request until ack is sampled high; the bound cuts a hang short.
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rd;
        q2 = rd2;
        cyc <= 1'b0; stb <= 1'b0;
        if (n >= 50) begin
            fails++;
            close_out();
        end
    endtask : wb
    task automatic pulse_cycles(input int k);
        repeat (k) @(posedge ref_clk);
        push <= 1'b0; pop <= 1'b0; skip <= 1'b0;
    endtask : pulse_cycles
    // ==========================================
    // Scenarios
    task automatic ext_irq;
        wb(1'b1, 4'h8, 8'h01);
        irq <= 1'b1;
        wb(1'b0, 4'h0, 8'h00); check("status", q, 8'h00);
        check("source", {7'h00, src}, 8'h01);
        irq <= 1'b0;
        wb(1'b0, 4'h0, 8'h00); check("status", q, 8'h08);
    endtask : ext_irq
    task automatic counter_event;
        wb(1'b1, 4'h8, 8'h02);
        c2 <= 1'b1;
        wb(1'b0, 4'h0, 8'h00); check("status", q, 8'h0C);
        check("cnt_irq", {7'h00, cirq}, 8'h01);
        c2 <= 1'b0;
        wb(1'b0, 4'h0, 8'h00); check("status", q, 8'h0C);
        wb(1'b1, 4'hA, 8'h5A);
        wb(1'b0, 4'h0, 8'h00); check("status", q, 8'h08);
    endtask : counter_event
    task automatic overflow_clear;
        push <= 1'b1;
        pulse_cycles(17);
        wb(1'b0, 4'h0, 8'h00); check("status", q, 8'h0B);
        check("orig_status", q2, 8'h0B);
        wb(1'b0, 4'h1, 8'h00); check("detail", q, 8'h02);
        wb(1'b1, 4'h9, 8'hFF);
        wb(1'b0, 4'h0, 8'h00); check("status", q, 8'h08);
        check("orig_status", q2, 8'h09);
        wb(1'b0, 4'h1, 8'h00); check("detail", q, 8'h00);
        check("orig_detail", q2, 8'h00);
    endtask : overflow_clear
    task automatic overrun_only;
        skip <= 1'b1;
        pulse_cycles(1);
        wb(1'b0, 4'h1, 8'h00); check("detail", q, 8'h01);
        wb(1'b0, 4'h0, 8'h00); check("status", q, 8'h08);
        check("orig_status", q2, 8'h0B);
        wb(1'b1, 4'h9, 8'h00);
        wb(1'b0, 4'h1, 8'h00); check("detail", q, 8'h00);
    endtask : overrun_only
    task automatic occupancy;
        push <= 1'b1;
        pulse_cycles(1);
        wb(1'b0, 4'h0, 8'h00); check("status", q, 8'h09);
        check("orig_status", q2, 8'h09);
        pop <= 1'b1;
        pulse_cycles(1);
        wb(1'b0, 4'h0, 8'h00); check("status", q, 8'h08);
        check("orig_status", q2, 8'h08);
        wb(1'b0, 4'h5, 8'h00); check("unmapped", q, 8'h00);
    endtask : occupancy
    initial begin
        ref_clk = 1'b0; rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0;
        dat = 8'h00; c2 = 1'b0; push = 1'b0; pop = 1'b0; skip = 1'b0; irq = 1'b0;
        fails = 0; compares = 0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        wb(1'b0, 4'h0, 8'h00); check("status", q, 8'h08);
        check("orig_status", q2, 8'h08);
        wb(1'b0, 4'h1, 8'h00); check("detail", q, 8'h00);
        check("orig_detail", q2, 8'h00);
        ext_irq();
        counter_event();
        overflow_clear();
        overrun_only();
        occupancy();
        close_out();
    end
endmodule : acquisition_status_flags_tb
`default_nettype wire
